// ---- design/mmp_top.sv ----
`timescale 1ns/10ps
module mmp_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_sup,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Access check
  input wire mmp_pkg::mmp_req_t i_req,
  output mmp_pkg::mmp_resp_t o_resp,
  // Exception to processor
  output logic o_exception
);
  // Request stage
  mmp_pkg::mmp_req_t req_reg;
  logic [3:0] eff_id;
  logic [6:0] pg_idx;
  logic [15:0] perm_word;
  logic [15:0] sw_word;
  logic [15:0] region_reg [mmp_pkg::DMA_REGIONS];

  // DMA engines have no own identifier; use programmer's
  assign eff_id = (i_req.src == mmp_pkg::MMP_SRC_LOCAL_DMA ||
                   i_req.src == mmp_pkg::MMP_SRC_CENTRAL_DMA) ?
                  i_req.prog_id : i_req.own_id;

  // Page index per space
  logic [6:0] prog_idx;
  logic [6:0] data_idx;
  logic [6:0] sec_idx;
  assign prog_idx = {3'h0, i_req.addr[14:11]};
  assign data_idx = 7'(mmp_pkg::L1_PAGES) + {3'h0, i_req.addr[14:11]};
  assign sec_idx = 7'(2 * mmp_pkg::L1_PAGES) + {2'h0, i_req.addr[19:15]};
  assign pg_idx = (i_req.space == mmp_pkg::MMP_SP_PROG) ? prog_idx :
                  (i_req.space == mmp_pkg::MMP_SP_DATA) ? data_idx : sec_idx;

  // Software side of permission store
  logic wb_req;
  logic pg_hit;
  logic rg_hit;
  logic [2:0] rg_idx;
  logic sw_we;
  logic pend_reg;
  logic [15:0] page_wdata;
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign pg_hit = i_wb_adr < mmp_pkg::OFF_REGION_BASE;
  assign rg_hit = i_wb_adr >= mmp_pkg::OFF_REGION_BASE &&
                  i_wb_adr < mmp_pkg::OFF_REGION_BASE + 12'h020;
  assign rg_idx = i_wb_adr[4:2];
  // Only supervisor may change protection config
  assign sw_we = pend_reg && wb_req && i_wb_we && i_wb_sup && pg_hit &&
                 (i_wb_sel[1:0] != 2'b00);
  // Unselected lanes keep the word read in the wait cycle
  assign page_wdata = {i_wb_sel[1] ? i_wb_dat[15:8] : sw_word[15:8],
                       i_wb_sel[0] ? i_wb_dat[7:0] : sw_word[7:0]};

  mmp_perm_ram u_ram (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_chk_idx(pg_idx),
    .o_chk_data(perm_word),
    .i_we(sw_we),
    .i_sw_idx(i_wb_adr[8:2]),
    .i_wdata(page_wdata),
    .o_sw_data(sw_word)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_reg <= '0;
    end else begin
      req_reg <= i_req;
      req_reg.own_id <= eff_id;
    end
  end

  // Decision on stage-1 data
  logic [15:0] rg_word;
  logic acc_ok;
  logic id_ok;
  logic lvl_ok;
  logic allow;
  logic is_cfg;
  assign is_cfg = req_reg.space == mmp_pkg::MMP_SP_DMACFG;
  assign rg_word = region_reg[req_reg.addr[14:12]];
  // Read/write/execute enables by privilege
  assign acc_ok = req_reg.sup ?
    perm_word[mmp_pkg::PB_SR + 32'(req_reg.acc)] :
    perm_word[mmp_pkg::PB_UR + 32'(req_reg.acc)];
  // Local bypasses id check, own enable
  assign id_ok = req_reg.local_acc ? perm_word[mmp_pkg::PB_LOCAL] :
    (req_reg.own_id < 4'h8 &&
     perm_word[mmp_pkg::PB_AID0 + 32'(req_reg.own_id[2:0])]);
  // Region check: id and privilege
  assign lvl_ok = req_reg.sup ? rg_word[mmp_pkg::RB_SUP] :
                  rg_word[mmp_pkg::RB_USER];
  assign allow = is_cfg ?
    (lvl_ok && req_reg.own_id < 4'h8 &&
     rg_word[mmp_pkg::RB_AID0 + 32'(req_reg.own_id[2:0])] &&
     req_reg.acc != mmp_pkg::MMP_AC_EXEC) :
    (acc_ok && id_ok);

  // Fault capture
  logic fault_reg;
  logic [31:0] fault_info_reg;
  logic [19:0] fault_addr_reg;
  logic viol;
  logic clr;
  assign viol = req_reg.valid && !allow;
  assign clr = wb_req && i_wb_we && i_wb_sup &&
               i_wb_adr == mmp_pkg::OFF_FAULT_CLR && i_wb_dat[0];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_resp <= '0;
      o_exception <= 1'b0;
      fault_reg <= 1'b0;
      fault_info_reg <= 32'h0000_0000;
      fault_addr_reg <= 20'h00000;
    end else begin
      // Gate to target; denied never passes
      o_resp.valid <= req_reg.valid;
      o_resp.allow <= req_reg.valid && allow;
      o_resp.addr <= req_reg.addr;
      // One-cycle exception per violation
      o_exception <= viol;
      if (viol) begin
        fault_reg <= 1'b1;
      end else if (clr) begin
        fault_reg <= 1'b0;
      end
      if (viol && !fault_reg) begin
        fault_addr_reg <= req_reg.addr;
        fault_info_reg <= {20'h00000, req_reg.own_id, 1'b0,
                           req_reg.local_acc, req_reg.sup,
                           req_reg.acc, req_reg.space, 1'b1};
      end
    end
  end

  // Region registers
  genvar g;
  generate
    for (g = 0; g < mmp_pkg::DMA_REGIONS; g++) begin : g_rg
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          region_reg[g] <= mmp_pkg::RPERM_RESET;
        end else if (wb_req && i_wb_we && i_wb_sup && rg_hit &&
                     rg_idx == 3'(g)) begin
          region_reg[g] <= i_wb_dat[15:0];
        end
      end
    end
  endgenerate

  // Wishbone answer: ack one cycle after request; page words, read
  // or written, wait on the registered store so take two
  logic [31:0] rd_mux;
  logic pg_acc;
  assign pg_acc = wb_req && pg_hit;
  assign rd_mux =
    rg_hit ? {16'h0000, region_reg[rg_idx]} :
    (i_wb_adr == mmp_pkg::OFF_FAULT_STAT) ? fault_info_reg &
      {31'h7FFFFFFF, fault_reg} :
    (i_wb_adr == mmp_pkg::OFF_FAULT_ADDR) ? {12'h000, fault_addr_reg} :
    (i_wb_adr == mmp_pkg::OFF_CTRL) ? 32'h0000_0000 :
    (i_wb_adr == mmp_pkg::OFF_FAULT_CLR) ? 32'h0000_0000 :
    mmp_pkg::BAD_ADDR_DATA;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pg_acc && !pend_reg;
      if (pend_reg) begin
        o_wb_ack <= 1'b1;
        o_wb_dat <= i_wb_we ? 32'h0000_0000 : {16'h0000, sw_word};
      end else if (wb_req && !pg_acc) begin
        o_wb_ack <= 1'b1;
        o_wb_dat <= i_wb_we ? 32'h0000_0000 : rd_mux;
      end else begin
        o_wb_ack <= 1'b0;
      end
    end
  end

  // Assertions
  property p_block;
    @(posedge i_clk) disable iff (!i_arst_n)
      (req_reg.valid && !allow) |=> (o_resp.valid && !o_resp.allow);
  endproperty
  a_block: assert property (p_block)
    else $error("denied access passed");

  property p_exc;
    @(posedge i_clk) disable iff (!i_arst_n)
      o_exception |-> (o_resp.valid && !o_resp.allow);
  endproperty
  a_exc: assert property (p_exc)
    else $error("exception without denial");

  property p_allow_exc;
    @(posedge i_clk) disable iff (!i_arst_n)
      o_resp.allow |-> !o_exception;
  endproperty
  a_allow_exc: assert property (p_allow_exc)
    else $error("exception on allowed access");

  property p_user_wr;
    @(posedge i_clk) disable iff (!i_arst_n)
      (wb_req && i_wb_we && !i_wb_sup && pg_hit) |-> !sw_we;
  endproperty
  a_user_wr: assert property (p_user_wr)
    else $error("user changed protection");

  property p_fault_sticky;
    @(posedge i_clk) disable iff (!i_arst_n)
      (viol || (fault_reg && !clr)) |=> fault_reg;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault flag lost");

  property p_dma_id;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_req.valid && i_req.src == mmp_pkg::MMP_SRC_CENTRAL_DMA)
      |=> req_reg.own_id == $past(i_req.prog_id);
  endproperty
  a_dma_id: assert property (p_dma_id)
    else $error("dma id not inherited");

  property p_ack_once;
    @(posedge i_clk) disable iff (!i_arst_n)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");

  property p_ack_soon;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_wb_cyc && i_wb_stb && !o_wb_ack) |-> ##[1:2] o_wb_ack;
  endproperty
  a_ack_soon: assert property (p_ack_soon)
    else $error("no ack");

  property p_lcl_dma_id;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_req.valid && i_req.src == mmp_pkg::MMP_SRC_LOCAL_DMA)
      |=> req_reg.own_id == $past(i_req.prog_id);
  endproperty
  a_lcl_dma_id: assert property (p_lcl_dma_id)
    else $error("local dma id not inherited");

  property p_cfg_noexec;
    @(posedge i_clk) disable iff (!i_arst_n)
      (req_reg.valid && is_cfg && req_reg.acc == mmp_pkg::MMP_AC_EXEC)
      |=> (o_resp.valid && !o_resp.allow && o_exception);
  endproperty
  a_cfg_noexec: assert property (p_cfg_noexec)
    else $error("fetch from dma config allowed");

  property p_fault_clr;
    @(posedge i_clk) disable iff (!i_arst_n)
      (clr && !viol) |=> !fault_reg;
  endproperty
  a_fault_clr: assert property (p_fault_clr)
    else $error("fault flag not cleared");

  property p_resp_lat;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_req.valid |-> ##2 (o_resp.valid &&
                           o_resp.addr == $past(i_req.addr, 2));
  endproperty
  a_resp_lat: assert property (p_resp_lat)
    else $error("response latency wrong");

  c_deny: cover property (@(posedge i_clk) o_exception);
  c_clr: cover property (@(posedge i_clk) clr && fault_reg);
  c_pg_wr: cover property (@(posedge i_clk) sw_we);
  c_allow: cover property (@(posedge i_clk) o_resp.allow);
  c_cfg: cover property (@(posedge i_clk) req_reg.valid && is_cfg && allow);
endmodule // mmp_top

// ---- design/mmp_pkg.sv ----
package mmp_pkg;
  // Requestor identity and request carrier
  localparam int ID_W = 4;
  localparam int NUM_CORES = 3;
  localparam int ADDR_W = 20;
  localparam logic [3:0] ID_LOCAL = 4'hF;

  // Memory spaces, pages and granularity
  localparam int L1_PAGES = 16;
  localparam int L1_PAGE_SHIFT = 11;
  localparam int SEC_PAGES = 64;
  localparam int SEC_PAGE_SHIFT = 15;
  localparam int TOT_PAGES = 2 * L1_PAGES + SEC_PAGES;
  localparam int PG_IDX_W = 7;
  localparam int DMA_REGIONS = 8;

  // Page permission word layout
  localparam int PB_UR = 0;
  localparam int PB_UW = 1;
  localparam int PB_UX = 2;
  localparam int PB_SR = 3;
  localparam int PB_SW = 4;
  localparam int PB_SX = 5;
  localparam int PB_LOCAL = 6;
  localparam int PB_AID0 = 8;
  localparam int PERM_W = 16;
  localparam logic [15:0] PERM_RESET = 16'hFF7F;

  // Region permission word layout
  localparam int RB_USER = 0;
  localparam int RB_SUP = 1;
  localparam int RB_AID0 = 8;
  localparam logic [15:0] RPERM_RESET = 16'hFF03;

  // Register map, byte addresses
  localparam logic [11:0] OFF_PAGE_BASE = 12'h000;
  localparam logic [11:0] OFF_REGION_BASE = 12'h200;
  localparam logic [11:0] OFF_FAULT_STAT = 12'h300;
  localparam logic [11:0] OFF_FAULT_ADDR = 12'h304;
  localparam logic [11:0] OFF_FAULT_CLR = 12'h308;
  localparam logic [11:0] OFF_CTRL = 12'h30C;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;

  typedef enum logic [1:0] {
    MMP_SP_PROG,
    MMP_SP_DATA,
    MMP_SP_SECOND,
    MMP_SP_DMACFG
  } mmp_space_t;

  typedef enum logic [1:0] {
    MMP_AC_READ,
    MMP_AC_WRITE,
    MMP_AC_EXEC
  } mmp_acc_t;

  typedef enum logic [1:0] {
    MMP_SRC_CORE,
    MMP_SRC_LOCAL_DMA,
    MMP_SRC_CENTRAL_DMA,
    MMP_SRC_PERIPH
  } mmp_src_t;

  typedef struct packed {
    logic valid;
    mmp_src_t src;
    logic [ID_W-1:0] own_id;
    logic [ID_W-1:0] prog_id;
    logic local_acc;
    logic sup;
    mmp_space_t space;
    mmp_acc_t acc;
    logic [ADDR_W-1:0] addr;
  } mmp_req_t;

  typedef struct packed {
    logic valid;
    logic allow;
    logic [ADDR_W-1:0] addr;
  } mmp_resp_t;
endpackage

// ---- design/mmp_perm_ram.sv ----
`timescale 1ns/10ps
module mmp_perm_ram (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Check port
  input wire logic [6:0] i_chk_idx,
  output logic [15:0] o_chk_data,
  // Software port
  input wire logic i_we,
  input wire logic [6:0] i_sw_idx,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_sw_data
);
  logic [15:0] mem_reg [mmp_pkg::TOT_PAGES];

  genvar g;
  generate
    for (g = 0; g < mmp_pkg::TOT_PAGES; g++) begin : g_pg
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          mem_reg[g] <= mmp_pkg::PERM_RESET;
        end else if (i_we && i_sw_idx == 7'(g)) begin
          mem_reg[g] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chk_data <= 16'h0000;
      o_sw_data <= 16'h0000;
    end else begin
      o_chk_data <= (i_chk_idx < 7'(mmp_pkg::TOT_PAGES)) ?
                    mem_reg[i_chk_idx] : 16'h0000;
      o_sw_data <= (i_sw_idx < 7'(mmp_pkg::TOT_PAGES)) ?
                   mem_reg[i_sw_idx] : 16'h0000;
    end
  end
endmodule // mmp_perm_ram

// ---- dv/mmp_master_model.sv ----
`timescale 1ns/10ps
module mmp_master_model (
  // Clock
  input wire logic i_clk,
  // Request to checker
  output mmp_pkg::mmp_req_t o_req
);
  initial o_req = '0;

  // One request for one cycle, then valid low and every other field inverted
  task automatic issue(input logic [1:0] src, input logic [3:0] own,
    input logic [3:0] prog, input logic loc, input logic sup,
    input logic [1:0] sp, input logic [1:0] acc, input logic [19:0] adr);
    logic [3:0] oid;
    // DMA has no identity of its own: its own field carries junk
    oid = (src == 2'h1 || src == 2'h2) ? ~prog : own;
    @(posedge i_clk);
    o_req <= {1'b1, src, oid, prog, loc, sup, sp, acc, adr};
    @(posedge i_clk);
    o_req <= {1'b0, ~o_req[$bits(o_req)-2:0]};
  endtask
endmodule // mmp_master_model

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  logic i_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, sup = 0;
  logic [11:0] adr = '0;
  logic [3:0] sel = 4'hF, bsel = 4'hF;
  logic [31:0] wdat = '0, rdat, q;
  logic ack, exc;
  mmp_pkg::mmp_req_t req;
  mmp_pkg::mmp_resp_t resp;
  int err_total = 0, cmp_count = 0, ncyc = 0;

  always #2 i_clk = ~i_clk;

  mmp_top mmp_top_i (.i_clk(i_clk), .i_arst_n(arst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .i_wb_sup(sup), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_req(req), .o_resp(resp), .o_exception(exc));
  mmp_master_model mmp_master_model_i (.i_clk(i_clk), .o_req(req));

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge i_clk) begin
    ncyc <= ncyc + 1;
    if (ncyc == 20000) begin
      err_total++;
      summarize;
    end
  end

  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic s, output logic [31:0] r);
    @(posedge i_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sup <= s;
    sel <= bsel;
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 0;
    stb <= 0;
    wdat <= ~d;
  endtask

  task automatic rq(input logic [1:0] s, input logic [3:0] o, p,
    input logic l, u, input logic [1:0] sp, ac, input logic [19:0] a,
    input logic e);
    int n;
    mmp_master_model_i.issue(s, o, p, l, u, sp, ac, a);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (resp.valid !== 1'b1 && n < 6);
    `CHK(resp.allow, e)
    `CHK(exc, ~e)
    `CHK(resp.addr, a)
  endtask

  task automatic t_reset;
    wb(0, mmp_pkg::OFF_PAGE_BASE, 0, 1, q);
    `CHK(q[15:0], mmp_pkg::PERM_RESET)
    wb(0, 12'h21C, 0, 1, q);
    `CHK(q[15:0], mmp_pkg::RPERM_RESET)
    wb(0, 12'h3F0, 0, 1, q);
    `CHK(q, mmp_pkg::BAD_ADDR_DATA)
    wb(1, 12'h000, 0, 0, q);
    wb(0, 12'h000, 0, 1, q);
    `CHK(q[15:0], mmp_pkg::PERM_RESET)
    bsel = 4'h2;
    wb(1, 12'h004, 32'h0000_ABCD, 1, q);
    bsel = 4'h1;
    wb(1, 12'h004, 32'h0000_1234, 1, q);
    bsel = 4'hF;
    wb(0, 12'h004, 0, 1, q);
    `CHK(q[15:0], 16'hAB34)
    $display("test reset and bus done");
  endtask

  task automatic t_rwx;
    logic [15:0] pm = 16'h0221;
    wb(1, 12'h04C, {16'h0, pm}, 1, q);
    for (int u = 0; u < 2; u++)
      for (int a = 0; a < 3; a++)
        rq(0, 1, 0, 0, u[0], 1, a[1:0], 20'h01800, pm[u*3+a]);
    rq(0, 1, 0, 0, 0, 1, 1, 20'h01FFF, 0);
    rq(0, 1, 0, 0, 0, 1, 1, 20'h02000, 1);
    rq(0, 1, 0, 0, 0, 0, 1, 20'h01800, 1);
    $display("test rwx done");
  endtask

  task automatic t_ids;
    wb(1, 12'h094, 32'h043F, 1, q);
    rq(0, 2, 0, 0, 1, 2, 0, 20'h28000, 1);
    rq(0, 1, 0, 0, 1, 2, 0, 20'h28000, 0);
    rq(3, 2, 0, 0, 1, 2, 0, 20'h28000, 1);
    rq(1, 0, 2, 0, 1, 2, 0, 20'h2FFFC, 1);
    rq(2, 0, 1, 0, 1, 2, 0, 20'h28000, 0);
    rq(0, 9, 0, 0, 1, 2, 0, 20'h28000, 0);
    rq(0, 1, 0, 0, 1, 2, 0, 20'h30000, 1);
    $display("test ids done");
  endtask

  task automatic t_local;
    wb(1, 12'h03C, 32'hFF3F, 1, q);
    rq(0, 0, 0, 1, 1, 0, 0, 20'h07800, 0);
    rq(0, 0, 0, 0, 1, 0, 0, 20'h07800, 1);
    wb(1, 12'h03C, 32'hFF7F, 1, q);
    rq(0, 0, 0, 1, 1, 0, 0, 20'h07800, 1);
    $display("test local done");
  endtask

  task automatic t_region;
    wb(1, 12'h208, 32'h0102, 1, q);
    rq(0, 0, 0, 0, 1, 3, 1, 20'h02000, 1);
    rq(0, 0, 0, 0, 0, 3, 1, 20'h02000, 0);
    rq(0, 1, 0, 0, 1, 3, 1, 20'h02000, 0);
    rq(0, 0, 0, 0, 1, 3, 2, 20'h02000, 0);
    rq(0, 1, 0, 0, 0, 3, 1, 20'h03000, 1);
    $display("test region done");
  endtask

  task automatic t_fault;
    wb(1, mmp_pkg::OFF_FAULT_CLR, 1, 1, q);
    rq(0, 1, 0, 0, 1, 2, 1, 20'h28000, 0);
    wb(0, mmp_pkg::OFF_FAULT_STAT, 0, 1, q);
    `CHK(q[11:0], 12'h12D)
    wb(0, mmp_pkg::OFF_FAULT_ADDR, 0, 1, q);
    `CHK(q[19:0], 20'h28000)
    wb(1, mmp_pkg::OFF_FAULT_CLR, 1, 1, q);
    wb(0, mmp_pkg::OFF_FAULT_STAT, 0, 1, q);
    `CHK(q[0], 1'b0)
    $display("test fault done");
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    arst_n <= 1;
    t_reset;
    t_rwx;
    t_ids;
    t_local;
    t_region;
    t_fault;
    summarize;
  end
endmodule // tb_top
